// ==== mshr_params.svh ====
`ifndef MSHR_PARAMS_SVH
`define MSHR_PARAMS_SVH

`define MSHR_REG_TIME_HI    16'h0004
`define MSHR_REG_TIME_LO    16'h0005
`define MSHR_REG_ERRORS     16'h0007
`define MSHR_REG_HEALTH     16'h0009
`define MSHR_REG_SPEED      16'h000A
`define MSHR_REG_DIR        16'h000B
`define MSHR_REG_CURRENT    16'h000C

`define MSHR_BIT_GPS        0
`define MSHR_BIT_MOTOR      2
`define MSHR_BIT_ANALOG     3

`define MSHR_HC_HEALTHY     16'h0000
`define MSHR_HC_JAM         16'h0001
`define MSHR_HC_MOTOR_COMM  16'h0003
`define MSHR_HC_HIGH_CUR    16'h0010
`define MSHR_HC_TEMP        16'h0030
`define MSHR_HC_SUPPLY      16'h0040
`define MSHR_HC_GPS_ACQ     16'h0100

`define MSHR_DIR_STOP       16'h0000
`define MSHR_DIR_FWD        16'h0001
`define MSHR_DIR_REV        16'h0003

`define MSHR_FUNC_READ      8'h03
`define MSHR_MAX_COUNT      16'h007D
`define MSHR_RESET_WORD     16'h0000

`define MSHR_CLK_HZ         250000000
`define MSHR_BAUD           19200
`define MSHR_BITS_PER_CHAR  4'hA

`endif

// ==== mshr_pkg.sv ====
package mshr_pkg;

   typedef logic [15:0] mshr_word_t;

   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0001,
      ST_FUNC  = 4'b0010,
      ST_COUNT = 4'b0100,
      ST_DATA  = 4'b1000
   } mshr_state_e;

endpackage

// ==== mshr_health.sv ====
`timescale 1ns/1ps
`include "mshr_params.svh"

module mshr_health
   import mshr_pkg::*;
(
   input  wire logic       motor_comm_fault,
   input  wire logic       aux_output_on,
   input  wire logic       motor_current_high,
   input  wire logic       temp_out_of_range,
   input  wire logic       supply4v_out_of_range,
   input  wire logic       jam_recovery_sequence,
   input  wire logic       gps_acquiring,
   output mshr_word_t      code
);

   // attention codes outrank normal-operation codes
   always_comb begin
      if (motor_comm_fault && aux_output_on) begin
         code = `MSHR_HC_MOTOR_COMM;
      end else if (motor_current_high) begin
         code = `MSHR_HC_HIGH_CUR;
      end else if (temp_out_of_range) begin
         code = `MSHR_HC_TEMP;
      end else if (supply4v_out_of_range) begin
         code = `MSHR_HC_SUPPLY;
      end else if (jam_recovery_sequence) begin
         code = `MSHR_HC_JAM;
      end else if (gps_acquiring) begin
         code = `MSHR_HC_GPS_ACQ;
      end else begin
         code = `MSHR_HC_HEALTHY;
      end
   end

endmodule

// ==== mshr_bank.sv ====
`timescale 1ns/1ps
`include "mshr_params.svh"

module mshr_bank
   import mshr_pkg::*;
#(
   parameter int unsigned BIT_CYCLES =
      `MSHR_CLK_HZ / `MSHR_BAUD
)
(
   input  wire logic        clock,
   input  wire logic        sys_rst,

   input  wire logic        gps_load,
   input  wire logic [31:0] gps_seconds,
   input  wire logic        gps_comm_fault,
   input  wire logic        gps_acquiring,

   input  wire logic        motor_comm_fault,
   input  wire logic        aux_output_on,
   input  wire logic        motor_current_high,
   input  wire logic        jam_recovery_sequence,
   input  wire logic        speed_load,
   input  wire logic [15:0] speed_hundredths,
   input  wire logic        rotor_running,
   input  wire logic        rotor_reverse,
   input  wire logic        current_load,
   input  wire logic [15:0] current_ma,

   input  wire logic        analog_limit_fault,
   input  wire logic        temp_out_of_range,
   input  wire logic        supply4v_out_of_range,

   input  wire logic        req_valid,
   input  wire logic [7:0]  req_func,
   input  wire logic [15:0] req_start,
   input  wire logic [15:0] req_count,
   output logic             req_ready,
   output logic             req_refused,

   output logic             bit_tick,
   output logic             tx_valid,
   output logic [7:0]       tx_byte,
   output logic             tx_last
);

   localparam logic [15:0] BIT_LAST =
      16'(BIT_CYCLES - 1);

   mshr_word_t  time_seconds_high;
   mshr_word_t  time_seconds_low;
   mshr_word_t  subsystem_error_flags;
   mshr_word_t  health_indicator_code;
   mshr_word_t  rotor_speed;
   mshr_word_t  rotor_direction;
   mshr_word_t  rotor_current_ma;
   mshr_word_t  next_health;

   mshr_state_e state;
   logic [15:0] rd_addr;
   logic [15:0] remain;
   logic        high_half;
   logic [15:0] bit_cnt;
   logic [3:0]  char_cnt;
   logic        slot_free;
   logic        issue;
   logic        accept;
   mshr_word_t  rd_word;

   // register index decode; holes read zero
   function automatic mshr_word_t reg_read(
      input logic [15:0] addr
   );
      unique case (addr)
         `MSHR_REG_TIME_HI: reg_read = time_seconds_high;
         `MSHR_REG_TIME_LO: reg_read = time_seconds_low;
         `MSHR_REG_ERRORS:  reg_read = subsystem_error_flags;
         `MSHR_REG_HEALTH:  reg_read = health_indicator_code;
         `MSHR_REG_SPEED:   reg_read = rotor_speed;
         `MSHR_REG_DIR:     reg_read = rotor_direction;
         `MSHR_REG_CURRENT: reg_read = rotor_current_ma;
         default:           reg_read = `MSHR_RESET_WORD;
      endcase
   endfunction

   function automatic logic count_ok(
      input logic [15:0] n
   );
      count_ok = (n != 16'h0000) &&
                 (n <= `MSHR_MAX_COUNT);
   endfunction

   mshr_health u_health (
      .motor_comm_fault      (motor_comm_fault),
      .aux_output_on         (aux_output_on),
      .motor_current_high    (motor_current_high),
      .temp_out_of_range     (temp_out_of_range),
      .supply4v_out_of_range (supply4v_out_of_range),
      .jam_recovery_sequence (jam_recovery_sequence),
      .gps_acquiring         (gps_acquiring),
      .code                  (next_health)
   );

   // epoch pair, written by the GPS receiver only
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         time_seconds_high <= `MSHR_RESET_WORD;
         time_seconds_low  <= `MSHR_RESET_WORD;
      end else if (gps_load) begin
         time_seconds_high <= gps_seconds[31:16];
         time_seconds_low  <= gps_seconds[15:0];
      end
   end

   // independent error bits
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         subsystem_error_flags <= `MSHR_RESET_WORD;
      end else begin
         subsystem_error_flags <= `MSHR_RESET_WORD;
         subsystem_error_flags[`MSHR_BIT_GPS]    <=
            gps_comm_fault;
         subsystem_error_flags[`MSHR_BIT_MOTOR]  <=
            motor_comm_fault;
         subsystem_error_flags[`MSHR_BIT_ANALOG] <=
            analog_limit_fault;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         health_indicator_code <= `MSHR_HC_HEALTHY;
      end else begin
         health_indicator_code <= next_health;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         rotor_speed <= `MSHR_RESET_WORD;
      end else if (speed_load) begin
         rotor_speed <= speed_hundredths;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         rotor_direction <= `MSHR_DIR_STOP;
      end else if (!rotor_running) begin
         rotor_direction <= `MSHR_DIR_STOP;
      end else if (rotor_reverse) begin
         rotor_direction <= `MSHR_DIR_REV;
      end else begin
         rotor_direction <= `MSHR_DIR_FWD;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         rotor_current_ma <= `MSHR_RESET_WORD;
      end else if (current_load) begin
         rotor_current_ma <= current_ma;
      end
   end

   // bit-rate enable for the outside serializer
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         bit_cnt  <= 16'h0000;
         bit_tick <= 1'b0;
      end else if (bit_cnt == BIT_LAST) begin
         bit_cnt  <= 16'h0000;
         bit_tick <= 1'b1;
      end else begin
         bit_cnt  <= bit_cnt + 16'h0001;
         bit_tick <= 1'b0;
      end
   end

   // one byte per ten-bit character slot
   assign slot_free = (char_cnt == `MSHR_BITS_PER_CHAR);
   assign issue     = slot_free && (state != ST_IDLE);

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         char_cnt <= `MSHR_BITS_PER_CHAR;
      end else if (issue) begin
         char_cnt <= 4'h0;
      end else if (bit_tick && !slot_free) begin
         char_cnt <= char_cnt + 4'h1;
      end
   end

   // function 3 reply sequencer
   assign req_ready = (state == ST_IDLE);
   assign accept    = req_valid && req_ready;
   always_comb begin
      rd_word = reg_read(rd_addr);
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         req_refused <= 1'b0;
      end else begin
         req_refused <= accept &&
            ((req_func != `MSHR_FUNC_READ) ||
             !count_ok(req_count));
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         state     <= ST_IDLE;
         rd_addr   <= 16'h0000;
         remain    <= 16'h0000;
         high_half <= 1'b1;
      end else begin
         unique case (state)
            ST_IDLE: begin
               if (accept && (req_func == `MSHR_FUNC_READ) &&
                   count_ok(req_count)) begin
                  state   <= ST_FUNC;
                  rd_addr <= req_start;
                  remain  <= req_count;
               end
            end
            ST_FUNC: begin
               if (issue) begin
                  state <= ST_COUNT;
               end
            end
            ST_COUNT: begin
               if (issue) begin
                  state     <= ST_DATA;
                  high_half <= 1'b1;
               end
            end
            ST_DATA: begin
               if (issue) begin
                  high_half <= !high_half;
                  if (!high_half) begin
                     rd_addr <= rd_addr + 16'h0001;
                     remain  <= remain - 16'h0001;
                     if (remain == 16'h0001) begin
                        state <= ST_IDLE;
                     end
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         tx_valid <= 1'b0;
         tx_byte  <= 8'h00;
         tx_last  <= 1'b0;
      end else begin
         tx_valid <= issue;
         tx_last  <= issue && (state == ST_DATA) &&
                     !high_half && (remain == 16'h0001);
         if (issue) begin
            unique case (state)
               ST_FUNC:  tx_byte <= `MSHR_FUNC_READ;
               ST_COUNT: tx_byte <= {remain[6:0], 1'b0};
               ST_DATA:  tx_byte <= high_half ?
                                    rd_word[15:8] :
                                    rd_word[7:0];
               default:  tx_byte <= tx_byte;
            endcase
         end
      end
   end

   // checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);

   logic [19:0] since_tx;
   always_ff @(posedge clock) begin
      if (sys_rst || tx_valid) begin
         since_tx <= 20'h00000;
      end else if (since_tx != 20'hFFFFF) begin
         since_tx <= since_tx + 20'h00001;
      end
   end

   property p_epoch_split;
      logic [31:0] s;
      (gps_load, s = gps_seconds) |=>
         {time_seconds_high, time_seconds_low} == s;
   endproperty
   a_epoch_split: assert property (p_epoch_split)
      else $error("epoch words do not match GPS value");

   property p_epoch_hold;
      !gps_load |=> $stable(time_seconds_high) &&
                    $stable(time_seconds_low);
   endproperty
   a_epoch_hold: assert property (p_epoch_hold)
      else $error("epoch changed without GPS load");

   property p_error_bits;
      1'b1 |=> subsystem_error_flags ==
         {12'h000, $past(analog_limit_fault),
          $past(motor_comm_fault), 1'b0,
          $past(gps_comm_fault)};
   endproperty
   a_error_bits: assert property (p_error_bits)
      else $error("error flags wrong");

   property p_analog_only;
      (analog_limit_fault && !motor_comm_fault &&
       !gps_comm_fault) |=> subsystem_error_flags == 16'h0008;
   endproperty
   a_analog_only: assert property (p_analog_only)
      else $error("analog fault alone not reading 8");

   property p_motor_prio;
      (motor_comm_fault && aux_output_on) |=>
         health_indicator_code == `MSHR_HC_MOTOR_COMM;
   endproperty
   a_motor_prio: assert property (p_motor_prio)
      else $error("motor comm code not shown");

   property p_healthy;
      !(motor_comm_fault && aux_output_on) &&
      !motor_current_high && !temp_out_of_range &&
      !supply4v_out_of_range && !jam_recovery_sequence &&
      !gps_acquiring |=> health_indicator_code == 16'h0000;
   endproperty
   a_healthy: assert property (p_healthy)
      else $error("healthy system not reading zero");

   property p_direction;
      1'b1 |=> rotor_direction ==
         (!$past(rotor_running) ? 16'h0000 :
          $past(rotor_reverse) ? 16'h0003 : 16'h0001);
   endproperty
   a_direction: assert property (p_direction)
      else $error("direction code wrong");

   property p_pacing;
      tx_valid && $past(tx_valid, 1) == 1'b0 |->
         since_tx >= 20'(BIT_CYCLES * 9 + 1) ||
         $past(state) == ST_FUNC;
   endproperty
   a_pacing: assert property (p_pacing)
      else $error("bytes closer than one character");

   sequence s_start;
      accept && req_func == `MSHR_FUNC_READ &&
      count_ok(req_count);
   endsequence
   sequence s_func_byte;
      tx_valid && tx_byte == `MSHR_FUNC_READ;
   endsequence
   property p_reply_head;
      s_start ##1 slot_free |=> s_func_byte;
   endproperty
   a_reply_head: assert property (p_reply_head)
      else $error("reply did not open with function code");

endmodule

// ==== mshr_master_model.sv ====
`timescale 1ns/1ps
module mshr_master_model
   import mshr_pkg::*;
#(
   parameter int GAP_CYCLES = 2
)
(
   input  wire logic        clock,
   input  wire logic        req_ready,
   input  wire logic        req_refused,
   input  wire logic        tx_valid,
   input  wire logic [7:0]  tx_byte,
   input  wire logic        tx_last,
   output logic             req_valid,
   output logic [7:0]       req_func,
   output logic [15:0]      req_start,
   output logic [15:0]      req_count
);
   logic [7:0] rx_q[$];
   logic       last_seen;
   logic       refused_seen;

   initial begin
      req_valid = 1'b0;
      req_func = 8'h00;
      req_start = 16'h0000;
      req_count = 16'h0000;
      last_seen = 1'b0;
      refused_seen = 1'b0;
   end

   // collect reply bytes one edge after they are issued
   always @(posedge clock) begin
      if (tx_valid === 1'b1) begin
         rx_q.push_back(tx_byte);
         last_seen <= tx_last;
      end
      if (req_refused === 1'b1) begin
         refused_seen <= 1'b1;
      end
   end

   // request held until taken, fields scrambled once released
   task automatic request(input logic [7:0] f, input logic [15:0] s, input logic [15:0] n, output bit ok);
      int i;
      ok = 1'b0;
      rx_q.delete();
      last_seen = 1'b0;
      refused_seen = 1'b0;
      repeat (GAP_CYCLES) @(negedge clock);
      req_valid = 1'b1;
      req_func = f;
      req_start = s;
      req_count = n;
      for (i = 0; i < 1000 && !ok; i++) begin
         @(posedge clock);
         ok = (req_ready === 1'b1);
      end
      @(negedge clock);
      req_valid = 1'b0;
      req_func = ~f;
      req_start = ~s;
      req_count = ~n;
   endtask
endmodule

// ==== mshr_bank_tb.sv ====
`timescale 1ns/1ps
module mshr_bank_tb
   import mshr_pkg::*;
;
   localparam int BITC = 4;
   logic        clock;
   logic        sys_rst;
   logic [10:0] lv;
   logic        gps_load;
   logic [31:0] gps_seconds;
   logic        speed_load;
   logic [15:0] speed_hundredths;
   logic        current_load;
   logic [15:0] current_ma;
   logic        req_valid;
   logic [7:0]  req_func;
   logic [15:0] req_start;
   logic [15:0] req_count;
   logic        req_ready;
   logic        req_refused;
   logic        bit_tick;
   logic        tx_valid;
   logic [7:0]  tx_byte;
   logic        tx_last;
   int unsigned exp_t;
   int          exp_s;
   int          exp_c;
   int          tk_gap;
   int          tx_gap;
   int          n_mismatch;
   int          tests_run;

   mshr_bank #(.BIT_CYCLES(BITC)) mshr_bank_i (.clock(clock), .sys_rst(sys_rst),
      .gps_load(gps_load), .gps_seconds(gps_seconds), .gps_comm_fault(lv[0]), .gps_acquiring(lv[1]),
      .motor_comm_fault(lv[2]), .aux_output_on(lv[3]), .motor_current_high(lv[4]),
      .jam_recovery_sequence(lv[5]), .speed_load(speed_load), .speed_hundredths(speed_hundredths),
      .rotor_running(lv[9]), .rotor_reverse(lv[10]), .current_load(current_load),
      .current_ma(current_ma), .analog_limit_fault(lv[6]), .temp_out_of_range(lv[7]),
      .supply4v_out_of_range(lv[8]), .req_valid(req_valid), .req_func(req_func),
      .req_start(req_start), .req_count(req_count), .req_ready(req_ready), .req_refused(req_refused),
      .bit_tick(bit_tick), .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_last(tx_last));

   mshr_master_model mshr_master_model_i (.clock(clock), .req_ready(req_ready),
      .req_refused(req_refused), .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_last(tx_last),
      .req_valid(req_valid), .req_func(req_func), .req_start(req_start), .req_count(req_count));

   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end

   task automatic wrap_up;
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic check(input logic [15:0] got, input int want);
      tests_run++;
      if (got !== want[15:0]) begin
         n_mismatch++;
         $display("[ERR] %0t got %0h want %0h", $time, got, want[15:0]);
      end
   endtask

   // reference register map
   function automatic int word(input int a);
      case (a)
         4: return exp_t >> 16;
         5: return exp_t & 'hFFFF;
         7: return lv[0] + 4 * lv[2] + 8 * lv[6];
         9: return (lv[2] && lv[3]) ? 3 : lv[4] ? 16 : lv[7] ? 48 : lv[8] ? 64 : lv[5] ? 1 : lv[1] ? 256 : 0;
         10: return exp_s;
         11: return lv[9] ? (lv[10] ? 3 : 1) : 0;
         12: return exp_c;
         default: return 0;
      endcase
   endfunction

   // bit pacing and character spacing
   always @(posedge clock) begin
      if (sys_rst) begin
         tk_gap <= -1000;
         tx_gap <= -1000;
      end else begin
         tk_gap <= (bit_tick === 1'b1) ? 1 : tk_gap + 1;
         tx_gap <= (tx_valid === 1'b1) ? 1 : tx_gap + 1;
         if (bit_tick === 1'b1 && tk_gap > 0) check(tk_gap, BITC);
         if (tx_valid === 1'b1 && tx_gap > 0) check(tx_gap >= 9 * BITC, 1);
      end
   end

   task automatic do_reset;
      @(negedge clock);
      sys_rst = 1'b1;
      lv = 11'h000;
      exp_t = 0;
      exp_s = 0;
      exp_c = 0;
      repeat (5) @(negedge clock);
      sys_rst = 1'b0;
   endtask

   task automatic read_regs(input logic [7:0] f, input int s, input int n);
      bit ok;
      bit bad;
      int i;
      int w;
      bad = (f != 8'h03 || n < 1 || n > 125);
      mshr_master_model_i.request(f, s[15:0], n[15:0], ok);
      if (!ok) begin
         n_mismatch++;
         wrap_up();
      end
      for (i = 0; i < 20000 && !mshr_master_model_i.last_seen && !mshr_master_model_i.refused_seen; i++)
         @(negedge clock);
      if (i >= 20000) begin
         n_mismatch++;
         wrap_up();
      end
      check(mshr_master_model_i.refused_seen, bad);
      check(mshr_master_model_i.last_seen, !bad);
      check(mshr_master_model_i.rx_q.size(), bad ? 0 : 2 * n + 2);
      if (mshr_master_model_i.rx_q.size() == 2 * n + 2 && !bad) begin
         for (i = 0; i < 2 * n + 2; i++) begin
            w = word(s + (i - 2) / 2);
            w = (i == 0) ? 3 : (i == 1) ? 2 * n : (i % 2 == 0) ? w >> 8 : w & 'hFF;
            check(mshr_master_model_i.rx_q[i], w);
         end
      end
   endtask

   task automatic trial(input int t);
      @(negedge clock);
      lv = (t < 11) ? 11'h001 << t : (t == 11) ? 11'h61C : 11'($urandom);
      gps_seconds = $urandom;
      speed_hundredths = 16'($urandom);
      current_ma = 16'($urandom);
      gps_load = 1'b1;
      speed_load = 1'b1;
      current_load = 1'b1;
      exp_t = gps_seconds;
      exp_s = speed_hundredths;
      exp_c = current_ma;
      @(negedge clock);
      gps_load = 1'b0;
      speed_load = 1'b0;
      current_load = 1'b0;
      gps_seconds = ~gps_seconds;
      speed_hundredths = ~speed_hundredths;
      current_ma = ~current_ma;
      read_regs(8'h03, 0, 16);
      read_regs(8'h03, $urandom_range(15), $urandom_range(6, 1));
   endtask

   initial begin
      sys_rst = 1'b1;
      lv = 11'h000;
      gps_load = 1'b0;
      gps_seconds = 32'h00000000;
      speed_load = 1'b0;
      speed_hundredths = 16'h0000;
      current_load = 1'b0;
      current_ma = 16'h0000;
      n_mismatch = 0;
      tests_run = 0;
      void'($urandom(94014));
      do_reset();
      read_regs(8'h03, 0, 13);
      for (int t = 0; t < 16; t++) trial(t);
      read_regs(8'h03, 5, 1);
      read_regs(8'h04, 4, 1);
      read_regs(8'h03, 4, 0);
      read_regs(8'h03, 0, 126);
      read_regs(8'h03, 0, 125);
      do_reset();
      read_regs(8'h03, 0, 13);
      wrap_up();
   end
endmodule
